// File: design/l1ccr_ctrl.v
`timescale 1ns/10ps
`include "l1ccr_defs.vh"
// ---------------------------------------------------------------
// l1 cache control and reservation
// ---------------------------------------------------------------
module l1ccr_ctrl #(
  parameter AW = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire hard_reset_i,
  input wire soft_reset_i,
  // impl control register write port
  input wire impl_wr_i,
  input wire [`L1CCR_IMPL_W-1:0] impl_wdata_i,
  output wire [`L1CCR_IMPL_W-1:0] impl_control_register_o,
  // load/store request
  input wire req_i,
  input wire [2:0] req_op_i,
  input wire [AW-1:0] req_addr_i,
  input wire [3:0] page_memory_attributes_i,
  input wire dc_hit_i,
  // l2 and bus completion for store-conditional
  input wire l2_hit_i,
  input wire wt_done_i,
  output reg done_o,
  output reg cond_field0_equal_bit_o,
  output reg align_exc_o,
  output reg bus_req_o,
  output reg [2:0] bus_tt_o,
  output reg bus_burst_o,
  output reg [AW-1:0] bus_addr_o,
  output reg l2_req_o,
  output reg dc_fill_o,
  output reg dc_update_o,
  output reg dc_op_o,
  output reg cache_inhibit_out_o,
  // snoop from the bus, pins from other clock domain
  input wire transfer_start_in_i,
  input wire global_access_in_i,
  input wire snp_write_i,
  input wire [AW-1:0] snp_addr_i,
  output wire snp_lookup_o,
  output wire snp_inval_o,
  output wire dc_refill_block_o,
  output wire dc_inval_o,
  output wire ic_inval_o,
  output wire rsv_valid_o,
  output wire [AW-1:0] rsv_addr_o
);
  // operation codes
  localparam OP_LOAD = 3'h0;
  localparam OP_STORE = 3'h1;
  localparam OP_LWR = 3'h2;
  localparam OP_STC = 3'h3;
  localparam OP_ZERO = 3'h4;
  localparam OP_TOUCH = 3'h5;
  localparam OP_BLKOP = 3'h6;
  // store-conditional states, one-hot
  localparam S_IDLE = 3'b001;
  localparam S_L2 = 3'b010;
  localparam S_BUS = 3'b100;

  reg [`L1CCR_IMPL_W-1:0] impl_q;
  reg [`L1CCR_IMPL_W-1:0] impl_d;
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg stc_hit_q;
  reg [AW-1:0] stc_addr_q;
  reg [2:0] ts_sync_q;
  reg [2:0] gbl_sync_q;
  reg snp_wr_q;
  reg [AW-1:0] snp_addr_q;
  reg hard_q;
  wire dce;
  wire dcache_lock_bit;
  wire ts_ok;
  wire gbl_ok;
  wire snp_qual;
  wire rsv_set;
  wire rsv_clr;
  wire rsv_valid;
  wire rsv_rst;
  wire idle;

  // reservation-flavoured transaction type
  function [2:0] tt_of;
    input rsv;
    input burst;
    input wr;
    begin
      tt_of = wr ? (rsv ? `L1CCR_TT_RSV_WRITE : `L1CCR_TT_WRITE) :
              burst ? (rsv ? `L1CCR_TT_RSV_BURST : `L1CCR_TT_BURST) :
              (rsv ? `L1CCR_TT_RSV_READ : `L1CCR_TT_READ);
    end
  endfunction

  assign dce = impl_q[`L1CCR_IMPL_DCE];
  assign dcache_lock_bit = impl_q[`L1CCR_IMPL_DCACHE_LOCK_BIT];
  assign idle = st_q[0];
  assign impl_control_register_o = impl_q;

  // ---------------------------------------------------------------
  // impl control register
  // ---------------------------------------------------------------
  // flash bits self-clear only while that cache is enabled
  always @* begin
    impl_d = impl_q;
    if (impl_q[`L1CCR_IMPL_DCACHE_FLASH_INVAL_BIT] && dce)
      impl_d[`L1CCR_IMPL_DCACHE_FLASH_INVAL_BIT] = 1'b0;
    if (impl_q[`L1CCR_IMPL_ICACHE_FLASH_INVAL_BIT] && impl_q[`L1CCR_IMPL_ICE])
      impl_d[`L1CCR_IMPL_ICACHE_FLASH_INVAL_BIT] = 1'b0;
    if (impl_wr_i)
      impl_d = impl_wdata_i; // software write wins
  end

  // soft reset keeps the register and cache contents
  always @(posedge clk_i) begin
    if (rst_i) begin
      impl_q <= `L1CCR_IMPL_RST;
      hard_q <= 1'b1;
    end else begin
      impl_q <= impl_d;
      hard_q <= hard_reset_i;
    end
  end

  // invalidate on hard reset or flash bit; a write-one then
  // write-zero pair also produces a pulse while the bit is high
  assign dc_inval_o = hard_q | impl_q[`L1CCR_IMPL_DCACHE_FLASH_INVAL_BIT];
  assign ic_inval_o = hard_q | impl_q[`L1CCR_IMPL_ICACHE_FLASH_INVAL_BIT];

  // ---------------------------------------------------------------
  // snoop input synchronisers
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ts_sync_q <= 3'h0;
      gbl_sync_q <= 3'h0;
      snp_wr_q <= 1'b0;
      snp_addr_q <= {AW{1'b0}};
    end else begin
      ts_sync_q <= {ts_sync_q[1:0], transfer_start_in_i};
      gbl_sync_q <= {gbl_sync_q[1:0], global_access_in_i};
      snp_wr_q <= snp_write_i;
      snp_addr_q <= snp_addr_i;
    end
  end

  // a high counts once stages two and three are both high; a low in either stage drops it
  assign ts_ok = ts_sync_q[1] & ts_sync_q[2];
  assign gbl_ok = gbl_sync_q[1] & gbl_sync_q[2];
  assign snp_qual = ts_ok & gbl_ok;
  // reservation watch is independent of cache enable
  assign snp_lookup_o = snp_qual & dce;
  // locked cache still loses lines to snoops; no refill while locked
  assign snp_inval_o = snp_lookup_o & snp_wr_q;
  assign dc_refill_block_o = dcache_lock_bit;

  // ---------------------------------------------------------------
  // reservation tracker
  // ---------------------------------------------------------------
  assign rsv_set = req_i && idle && req_op_i == OP_LWR;
  assign rsv_clr = req_i && idle && req_op_i == OP_STC;
  assign rsv_rst = rst_i | hard_reset_i | soft_reset_i;

  l1ccr_rsv #(
    .AW(AW)
  ) u_rsv (
    .clk_i(clk_i),
    .rst_i(rsv_rst),
    .set_i(rsv_set),
    .set_addr_i(req_addr_i),
    .clr_i(rsv_clr),
    .snp_kill_i(snp_qual & snp_wr_q),
    .snp_addr_i(snp_addr_q),
    .valid_o(rsv_valid),
    .addr_o(rsv_addr_o)
  );
  assign rsv_valid_o = rsv_valid;

  // ---------------------------------------------------------------
  // store-conditional sequencer
  // ---------------------------------------------------------------
  always @* begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (rsv_clr && rsv_valid)
          st_d = l2_hit_i ? S_L2 : S_BUS;
      end
      S_L2, S_BUS: begin
        if (wt_done_i)
          st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      stc_hit_q <= 1'b0;
      stc_addr_q <= {AW{1'b0}};
    end else begin
      st_q <= st_d;
      if (rsv_clr) begin
        stc_hit_q <= dc_hit_i;
        stc_addr_q <= req_addr_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // request routing, registered outputs
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      cond_field0_equal_bit_o <= 1'b0;
      align_exc_o <= 1'b0;
      bus_req_o <= 1'b0;
      bus_tt_o <= `L1CCR_TT_READ;
      bus_burst_o <= 1'b0;
      bus_addr_o <= {AW{1'b0}};
      l2_req_o <= 1'b0;
      dc_fill_o <= 1'b0;
      dc_update_o <= 1'b0;
      dc_op_o <= 1'b0;
      cache_inhibit_out_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      align_exc_o <= 1'b0;
      bus_req_o <= 1'b0;
      l2_req_o <= 1'b0;
      dc_fill_o <= 1'b0;
      dc_update_o <= 1'b0;
      dc_op_o <= 1'b0;
      if (req_i && idle) begin
        cache_inhibit_out_o <=
          page_memory_attributes_i[`L1CCR_ATTR_I];
        bus_addr_o <= req_addr_i;
        case (req_op_i)
          OP_LOAD, OP_LWR: begin
            // non-inhibited hits served; disabled ignores tags entirely
            if (dce && dc_hit_i &&
                !page_memory_attributes_i[`L1CCR_ATTR_I]) begin
              done_o <= 1'b1;
            end else if (dce && !dcache_lock_bit &&
                !page_memory_attributes_i[`L1CCR_ATTR_I]) begin
              dc_fill_o <= 1'b1;
              bus_req_o <= 1'b1;
              bus_burst_o <= 1'b1;
              bus_tt_o <= tt_of(req_op_i == OP_LWR, 1'b1,
                                1'b0);
            end else begin
              // single beat: inhibited, locked or disabled
              bus_req_o <= 1'b1;
              bus_burst_o <= 1'b0;
              bus_tt_o <= tt_of(req_op_i == OP_LWR, 1'b0,
                                1'b0);
            end
          end
          OP_STORE: begin
            bus_req_o <= !dce || dcache_lock_bit ||
                         page_memory_attributes_i[`L1CCR_ATTR_W] ||
                         page_memory_attributes_i[`L1CCR_ATTR_I];
            bus_burst_o <= 1'b0;
            bus_tt_o <= `L1CCR_TT_WRITE;
            dc_update_o <= dce && dc_hit_i &&
                           !page_memory_attributes_i[`L1CCR_ATTR_I];
            done_o <= 1'b1;
          end
          OP_STC: begin
            if (!rsv_valid) begin
              // retire quietly, no bus and no cache change
              done_o <= 1'b1;
              cond_field0_equal_bit_o <= 1'b0;
            end else if (l2_hit_i) begin
              l2_req_o <= 1'b1;
            end else begin
              // write-through regardless of page attributes
              bus_req_o <= 1'b1;
              bus_burst_o <= 1'b0;
              bus_tt_o <= tt_of(1'b1, 1'b0, 1'b1);
            end
          end
          OP_ZERO: begin
            align_exc_o <= !dce;
            dc_op_o <= dce;
            done_o <= 1'b1;
          end
          OP_TOUCH: begin
            dc_op_o <= dce;
            done_o <= 1'b1;
          end
          OP_BLKOP: begin
            dc_op_o <= 1'b1;
            done_o <= 1'b1;
          end
          default: done_o <= 1'b1;
        endcase
      end else if (!idle && wt_done_i) begin
        done_o <= 1'b1;
        cond_field0_equal_bit_o <= 1'b1;
        dc_update_o <= stc_hit_q && dce;
        bus_addr_o <= stc_addr_q;
      end
    end
  end
endmodule // l1ccr_ctrl

// File: design/l1ccr_defs.vh
`ifndef L1CCR_DEFS_VH
`define L1CCR_DEFS_VH
// reservation granule: 32 bytes, so 5 offset bits
`define L1CCR_GRANULE_BYTES 32
`define L1CCR_GRANULE_LSB 5
// impl control register field positions
`define L1CCR_IMPL_ICACHE_FLASH_INVAL_BIT 0
`define L1CCR_IMPL_DCACHE_FLASH_INVAL_BIT 1
`define L1CCR_IMPL_DCACHE_LOCK_BIT 2
`define L1CCR_IMPL_DCE 3
`define L1CCR_IMPL_ICE 4
`define L1CCR_IMPL_W 5
`define L1CCR_IMPL_RST 5'h00
// page attribute bits (w i m g, msb first)
`define L1CCR_ATTR_W 3
`define L1CCR_ATTR_I 2
`define L1CCR_ATTR_M 1
// transaction type codes
`define L1CCR_TT_READ 3'h0
`define L1CCR_TT_BURST 3'h1
`define L1CCR_TT_WRITE 3'h2
`define L1CCR_TT_RSV_READ 3'h4
`define L1CCR_TT_RSV_BURST 3'h5
`define L1CCR_TT_RSV_WRITE 3'h6
// flash invalidate duration in clocks
`define L1CCR_INVAL_CYC 1
`endif

// File: design/l1ccr_rsv.v
`timescale 1ns/10ps
`include "l1ccr_defs.vh"
// ---------------------------------------------------------------
// reservation tracker
// ---------------------------------------------------------------
module l1ccr_rsv #(
  parameter AW = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire set_i,
  input wire [AW-1:0] set_addr_i,
  input wire clr_i,
  input wire snp_kill_i,
  input wire [AW-1:0] snp_addr_i,
  output wire valid_o,
  output wire [AW-1:0] addr_o
);
  localparam GL = `L1CCR_GRANULE_LSB;
  reg valid_q;
  reg [AW-GL-1:0] gran_q;
  wire snp_match;

  // snoop match on granule only
  assign snp_match = snp_kill_i && valid_q &&
                     (snp_addr_i[AW-1:GL] == gran_q);

  // set beats clear: a new reservation replaces any old one
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      gran_q <= {(AW-GL){1'b0}};
    end else if (set_i) begin
      valid_q <= 1'b1;
      gran_q <= set_addr_i[AW-1:GL];
    end else if (clr_i || snp_match) begin
      valid_q <= 1'b0;
    end
  end

  assign valid_o = valid_q;
  assign addr_o = {gran_q, {GL{1'b0}}};
endmodule // l1ccr_rsv

// File: dv/l1ccr_ctrl_assertions.sv
`timescale 1ns/10ps
// ---------------------------------------------
// l1 cache control checker
// ---------------------------------------------
module l1ccr_chk #(
  parameter AW = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire hard_reset_i,
  input wire soft_reset_i,
  input wire transfer_start_in_i,
  input wire global_access_in_i,
  input wire impl_wr_i,
  input wire [4:0] impl_control_register_o,
  input wire req_i,
  input wire [2:0] req_op_i,
  input wire [AW-1:0] req_addr_i,
  input wire [3:0] page_memory_attributes_i,
  input wire dc_hit_i,
  input wire done_o,
  input wire cond_field0_equal_bit_o,
  input wire bus_req_o,
  input wire l2_req_o,
  input wire [2:0] bus_tt_o,
  input wire bus_burst_o,
  input wire cache_inhibit_out_o,
  input wire snp_lookup_o,
  input wire dc_inval_o,
  input wire ic_inval_o,
  input wire rsv_valid_o,
  input wire [AW-1:0] rsv_addr_o
);
  // one domain; reset masks every check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [4:0] im = impl_control_register_o;
  wire [3:0] at = page_memory_attributes_i;
  // the request checks are only valid while requests arrive with the sequencer idle
  rst_state_a: assert property (
    $fell(rst_i) |-> !rsv_valid_o && im == 5'h00 && dc_inval_o && ic_inval_o)
    else $error("state wrong after reset");
  hard_inv_a: assert property (
    hard_reset_i |=> dc_inval_o && ic_inval_o)
    else $error("hard reset did not invalidate");
  lr_set_a: assert property (
    req_i && req_op_i == 3'h2 |=> rsv_valid_o
      && rsv_addr_o[AW-1:5] == $past(req_addr_i[AW-1:5]))
    else $error("reservation not set on granule");
  sc_clr_a: assert property (
    req_i && req_op_i == 3'h3 |=> !rsv_valid_o)
    else $error("reservation kept after store-cond");
  sc_fail_a: assert property (
    req_i && req_op_i == 3'h3 && !rsv_valid_o |=> done_o
      && !cond_field0_equal_bit_o && !bus_req_o && !l2_req_o)
    else $error("failed store-cond wrong");
  lr_bus_a: assert property (
    req_i && req_op_i == 3'h2 && !dc_hit_i |=> bus_req_o && bus_tt_o[2]
      && bus_burst_o == $past(im[3] && !im[2] && !at[2]))
    else $error("load-reserve bus request wrong");
  ci_a: assert property (
    req_i |=> cache_inhibit_out_o == $past(at[2]))
    else $error("inhibit output wrong");
  dcache_flash_inval_bit_a: assert property (
    im[1] && im[3] |-> $rose(im[1]) || $past(impl_wr_i))
    else $error("dcache flash bit held");
  icache_flash_inval_bit_a: assert property (
    im[0] && im[4] |-> $rose(im[0]) || $past(impl_wr_i))
    else $error("icache flash bit held");
  snp_dce_a: assert property (
    snp_lookup_o == (im[3] && $past(transfer_start_in_i, 2)
      && $past(transfer_start_in_i, 3) && $past(global_access_in_i, 2)
      && $past(global_access_in_i, 3)))
    else $error("snoop lookup wrong");
  rsv_drop_a: assert property (
    hard_reset_i || soft_reset_i |=> !rsv_valid_o)
    else $error("reservation kept over reset");
endmodule // l1ccr_chk

bind l1ccr_ctrl l1ccr_chk #(.AW(AW)) u_chk (.clk_i, .rst_i, .hard_reset_i,
  .soft_reset_i, .transfer_start_in_i, .global_access_in_i,
  .impl_wr_i, .impl_control_register_o, .req_i, .req_op_i, .req_addr_i,
  .page_memory_attributes_i, .dc_hit_i, .done_o, .cond_field0_equal_bit_o,
  .bus_req_o, .l2_req_o, .bus_tt_o, .bus_burst_o, .cache_inhibit_out_o,
  .snp_lookup_o, .dc_inval_o, .ic_inval_o, .rsv_valid_o, .rsv_addr_o);

// File: dv/l1ccr_far.sv
`timescale 1ns/10ps
// ---------------------------------------------
// l2 and bus write-through completion model
// ---------------------------------------------
module l1ccr_far (
  input wire clk_i,
  input wire go_i,
  input wire [3:0] dly_i,
  output reg wt_done_o
);
  reg [3:0] cnt_q = 4'h0;
  // done pulse dly_i cycles after the request; dly_i must be nonzero
  always @(posedge clk_i) begin
    wt_done_o <= (cnt_q == 4'h1);
    if (go_i) begin
      cnt_q <= dly_i;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // l1ccr_far

// File: dv/tb.sv
`timescale 1ns/10ps
// ---------------------------------------------
// l1 cache control testbench
// ---------------------------------------------
module tb;
  reg clk_i, rst_i, hard_reset_i, soft_reset_i, impl_wr_i, req_i;
  reg dc_hit_i, l2_hit_i, ts, global_access_in, snp_write_i;
  reg [4:0] impl_wdata_i;
  reg [2:0] req_op_i;
  reg [3:0] att, dly;
  reg [31:0] req_addr_i, snp_addr_i;
  wire wt_done_i, done_o, eq, align_exc_o, bus_req_o, bus_burst_o, ci;
  wire l2_req_o, dc_fill_o, dc_update_o, dc_op_o, dc_inval_o, ic_inval_o;
  wire rsv_valid_o, snp_lookup_o, snp_inval_o, dc_refill_block_o;
  wire [4:0] im;
  wire [2:0] bus_tt_o;
  wire [31:0] rsv_addr_o, bus_addr_o;
  integer n_errors = 0, tests_run = 0, i, k;
  l1ccr_ctrl #(.AW(32)) uut (.clk_i, .rst_i, .hard_reset_i, .soft_reset_i,
    .impl_wr_i, .impl_wdata_i, .impl_control_register_o(im), .req_i,
    .req_op_i, .req_addr_i, .page_memory_attributes_i(att), .dc_hit_i,
    .l2_hit_i, .wt_done_i, .done_o, .cond_field0_equal_bit_o(eq),
    .align_exc_o, .bus_req_o, .bus_tt_o, .bus_burst_o, .bus_addr_o,
    .l2_req_o, .dc_fill_o, .dc_update_o, .dc_op_o, .cache_inhibit_out_o(ci),
    .transfer_start_in_i(ts), .global_access_in_i(global_access_in), .snp_write_i,
    .snp_addr_i, .snp_lookup_o, .snp_inval_o, .dc_refill_block_o,
    .dc_inval_o, .ic_inval_o, .rsv_valid_o, .rsv_addr_o);
  // only write-through requests start a completion
  l1ccr_far far (.clk_i, .go_i(l2_req_o | (bus_req_o & bus_tt_o[1])),
    .dly_i(dly), .wt_done_o(wt_done_i));
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  task chk(input [63:0] got, input [63:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0t: got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wr_impl(input [4:0] v);
    begin
      @(posedge clk_i);
      impl_wr_i <= 1'b1;
      impl_wdata_i <= v;
      @(posedge clk_i);
      impl_wr_i <= 1'b0;
      #1;
    end
  endtask
  // hit is {l2 hit, dcache hit}; returns settled just after the edge that accepts the request
  task req(input [2:0] op, input [31:0] a, input [3:0] at, input [1:0] hit);
    begin
      @(posedge clk_i);
      req_i <= 1'b1;
      req_op_i <= op;
      req_addr_i <= a;
      att <= at;
      {l2_hit_i, dc_hit_i} <= hit;
      @(posedge clk_i);
      req_i <= 1'b0;
      #1;
    end
  endtask
  task wait_done;
    for (k = 0; k < 20 && done_o !== 1'b1; k = k + 1) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // released pins show the inverted address, not the last one
  // lk: a qualified snoop with the dcache on looks up and invalidates
  task snoop(input [31:0] a, input t, input g, input exp, input lk);
    begin
      @(posedge clk_i);
      {ts, global_access_in, snp_write_i, snp_addr_i} <= {t, g, 1'b1, a};
      repeat (4) @(posedge clk_i);
      {ts, global_access_in, snp_write_i, snp_addr_i} <= {3'b000, ~a};
      #1 chk({snp_lookup_o, snp_inval_o}, {lk, lk});
      repeat (4) @(posedge clk_i);
      #1;
      chk(rsv_valid_o, exp);
    end
  endtask
  task t_reset;
    begin
      chk({im, rsv_valid_o}, 6'h00);
      req(3'h2, 32'h1000_0000, 4'h0, 2'b00);
      @(posedge clk_i);
      hard_reset_i <= 1'b1;
      @(posedge clk_i);
      hard_reset_i <= 1'b0;
      #1 chk({dc_inval_o, ic_inval_o, rsv_valid_o}, 3'b110);
      wr_impl(5'h04);
      req(3'h2, 32'h1000_0000, 4'h0, 2'b00);
      @(posedge clk_i);
      soft_reset_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      @(posedge clk_i);
      // soft reset keeps the register and caches, drops the reservation
      #1 chk({dc_inval_o, ic_inval_o, rsv_valid_o, im}, 8'h04);
      wr_impl(5'h00);
    end
  endtask
  task t_flash;
    begin
      wr_impl(5'h0A);
      chk(dc_inval_o, 1);
      @(posedge clk_i);
      #1 chk(im, 5'h08);
      wr_impl(5'h02);
      repeat (3) @(posedge clk_i);
      #1 chk({im, dc_inval_o}, {5'h02, 1'b1});
      wr_impl(5'h00);
      chk(im, 5'h00);
      wr_impl(5'h11);
      chk(ic_inval_o, 1);
      @(posedge clk_i);
      #1 chk(im, 5'h10);
    end
  endtask
  // cacheable, inhibited, locked, disabled load-reserve misses
  task t_lr;
    for (i = 0; i < 4; i = i + 1) begin
      wr_impl(i == 2 ? 5'h0C : i == 3 ? 5'h00 : 5'h08);
      req(3'h2, 32'h1000_0044, i == 1 ? 4'h4 : 4'h0, 2'b00);
      chk({bus_req_o, bus_tt_o, bus_burst_o, dc_fill_o, ci},
        {1'b1, i == 0 ? 3'h5 : 3'h4, i == 0, i == 0, i == 1});
      chk({rsv_valid_o, rsv_addr_o[31:5]}, {1'b1, 27'h080_0002});
    end
  endtask
  task t_dis;
    begin
      req(3'h0, 32'h1000_0000, 4'h0, 2'b01);
      chk({bus_req_o, bus_burst_o, bus_tt_o}, 5'b1_0000);
      req(3'h1, 32'h1000_0000, 4'h0, 2'b01);
      chk({bus_req_o, bus_tt_o, dc_update_o}, 5'b1_0100);
      req(3'h4, 32'h1000_0000, 4'h0, 2'b01);
      chk(align_exc_o, 1);
      req(3'h5, 32'h1000_0000, 4'h0, 2'b00);
      chk({bus_req_o, dc_fill_o}, 2'b00);
      req(3'h6, 32'h1000_0000, 4'h0, 2'b01);
      chk(dc_op_o, 1);
      wr_impl(5'h08);
    end
  endtask
  task t_sc;
    begin
      dly = 4'h1;
      req(3'h2, 32'h2000_0040, 4'h0, 2'b01);
      req(3'h3, 32'h3000_0000, 4'h0, 2'b11);
      chk({l2_req_o, bus_req_o, rsv_valid_o}, 3'b100);
      wait_done;
      chk({done_o, eq, dc_update_o}, 3'b111);
      chk(bus_addr_o, 32'h3000_0000);
      dly = 4'h6;
      req(3'h2, 32'h2000_0040, 4'hC, 2'b00);
      req(3'h3, 32'h2000_0040, 4'h0, 2'b00);
      chk({bus_req_o, bus_tt_o, l2_req_o}, 5'b1_1100);
      wait_done;
      chk({done_o, eq, dc_update_o}, 3'b110);
      req(3'h3, 32'h2000_0040, 4'h0, 2'b11);
      chk({done_o, eq, bus_req_o, l2_req_o, dc_update_o}, 5'h10);
      chk(rsv_valid_o, 0);
    end
  endtask
  task t_snoop;
    begin
      req(3'h2, 32'h2000_0040, 4'h0, 2'b01);
      snoop(32'h2000_0060, 1'b1, 1'b1, 1'b1, 1'b1);
      snoop(32'h2000_0044, 1'b1, 1'b0, 1'b1, 1'b0);
      snoop(32'h2000_0044, 1'b0, 1'b1, 1'b1, 1'b0);
      wr_impl(5'h0C);
      chk(dc_refill_block_o, 1);
      snoop(32'h2000_005C, 1'b1, 1'b1, 1'b0, 1'b1);
      wr_impl(5'h00);
      req(3'h2, 32'h2000_0040, 4'h0, 2'b00);
      snoop(32'h2000_0048, 1'b1, 1'b1, 1'b0, 1'b0);
    end
  endtask
  initial begin
    {rst_i, hard_reset_i, soft_reset_i, impl_wr_i, req_i} = 5'h10;
    {dc_hit_i, l2_hit_i, ts, global_access_in, snp_write_i} = 5'h00;
    {impl_wdata_i, req_op_i, att, dly} = 16'h0001;
    {req_addr_i, snp_addr_i} = 64'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset;
    t_flash;
    t_lr;
    t_dis;
    t_sc;
    t_snoop;
    summarize;
  end
  initial begin
    #400000;
    n_errors = n_errors + 1;
    summarize;
  end
endmodule // tb
